/* File: rbm_core.sv */
/*
 * Receive buffer manager: walks the descriptor ring, fills buffers and
 * writes status back. Assumes the memory port accepts a held request and
 * answers with a one-cycle ack, read data valid with that ack.
 */
`timescale 1ns/1ns
module rbm_core #(
    parameter int DESC_MAX = rbm_pkg::RBM_DESC_MAX,
    parameter int BUF_BYTES = rbm_pkg::RBM_BUF_BYTES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Receive front end
    input wire logic RX_START,
    input wire logic RX_COPY,
    input wire logic RX_DROP,
    input wire rbm_pkg::rbm_match_t RX_MATCH,
    input wire logic RX_VALID,
    input wire rbm_pkg::rbm_beat_t RX_BEAT,
    output logic RX_READY,
    input wire logic RX_ERR,
    // Memory master
    output logic MEM_REQ,
    output rbm_pkg::rbm_mem_t MEM_OUT,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    // Events
    output logic BNA_EVENT
);
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_FETCH = 9'h002,
        S_WAITC = 9'h004,
        S_FILL = 9'h008,
        S_WDATA = 9'h010,
        S_WSTAT = 9'h020,
        S_WOWN = 9'h040,
        S_DISC = 9'h080,
        S_SPARE = 9'h100
    } rbm_state_t;

    rbm_state_t state, next_state;
    logic [31:0] ctrl, cfg, qbase, desc0, wbuf;
    logic [9:0] idx;
    logic [7:0] pos;
    logic [4:0] wword;
    logic [13:0] len;
    logic sof, eof, cont, pend, bna, err_pend, primed, copy_ok;
    rbm_pkg::rbm_match_t match;
    logic [31:0] stat_word;

    default clocking chk_clk @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    // =========================================================
    // Register port
    wire logic rx_en = ctrl[rbm_pkg::RBM_CTRL_RXEN];
    wire logic jumbo = cfg[rbm_pkg::RBM_CFG_JUMBO];
    wire logic [1:0] cfg_ofs = cfg[rbm_pkg::RBM_CFG_OFS_LO +: 2];
    wire logic nofcs = cfg[rbm_pkg::RBM_CFG_NOFCS];
    wire logic wr_ctrl = REG_WR && (REG_ADDR == rbm_pkg::RBM_OFS_CTRL);
    wire logic wr_cfg = REG_WR && (REG_ADDR == rbm_pkg::RBM_OFS_CFG);
    wire logic wr_qptr = REG_WR && (REG_ADDR == rbm_pkg::RBM_OFS_QPTR);
    wire logic wr_stat = REG_WR && (REG_ADDR == rbm_pkg::RBM_OFS_STAT);
    wire logic [31:0] desc_addr = qbase + {19'h00000, idx, 3'b000};
    wire logic busy = (state != S_IDLE);
    wire logic [31:0] rd_mux =
        (REG_ADDR == rbm_pkg::RBM_OFS_CTRL) ? ctrl :
        (REG_ADDR == rbm_pkg::RBM_OFS_CFG) ? cfg :
        (REG_ADDR == rbm_pkg::RBM_OFS_QPTR) ? desc_addr :
        (REG_ADDR == rbm_pkg::RBM_OFS_STAT) ? {30'h0, busy, bna} : 32'h0000_0000;

    // =========================================================
    // Datapath decode
    wire logic ack_fetch = (state == S_FETCH) && MEM_ACK;
    wire logic ack_data = (state == S_WDATA) && MEM_ACK;
    wire logic ack_own = (state == S_WOWN) && MEM_ACK;
    wire logic owned = MEM_RDATA[rbm_pkg::RBM_D0_OWN];
    wire logic wrap = desc0[rbm_pkg::RBM_D0_WRAP] || (idx == 10'(DESC_MAX - 1));
    wire logic [31:0] buf_base = {desc0[31:2], 2'b00};
    wire logic beat_ok = RX_VALID && RX_READY;
    wire logic drop_fcs = RX_BEAT.fcs && nofcs;
    wire logic take = beat_ok && (state == S_FILL) && !drop_fcs;
    wire logic [1:0] lane = pos[1:0];
    wire logic [7:0] pos_inc = pos + 8'h01;
    wire logic err_now = RX_ERR || err_pend;
    wire logic buf_full = (pos == 8'(BUF_BYTES));
    wire logic req_state = (state == S_FETCH) || (state == S_WDATA) ||
                           (state == S_WSTAT) || (state == S_WOWN);
    logic [31:0] next_wbuf;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign next_wbuf[gi*8 +: 8] = (take && lane == gi) ? RX_BEAT.data :
                                           wbuf[gi*8 +: 8];
        end
    endgenerate

    wire logic [31:0] mem_addr_mux =
        (state == S_WDATA) ? buf_base + {25'h0, wword, 2'b00} :
        (state == S_WSTAT) ? desc_addr + rbm_pkg::RBM_STAT_WORD_OFS : desc_addr;
    wire logic [31:0] mem_data_mux =
        (state == S_WDATA) ? wbuf :
        (state == S_WSTAT) ? stat_word : (desc0 | 32'h0000_0001);

    rbm_stat u_stat (
        .sof(sof),
        .eof(eof),
        .match(match),
        .offset(cfg_ofs),
        .jumbo(jumbo),
        .len(len),
        .word(stat_word)
    );

    // =========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (RX_START && rx_en) next_state = S_FETCH;
            end
            S_FETCH: begin
                if (MEM_ACK) begin
                    if (owned) next_state = S_DISC;
                    else if (cont) next_state = S_FILL;
                    else next_state = S_WAITC;
                end
            end
            S_WAITC: begin
                if (err_now || RX_DROP) next_state = S_IDLE;
                else if (RX_COPY) next_state = S_FILL;
            end
            S_FILL: begin
                if (err_now) next_state = S_IDLE;
                else if (buf_full) next_state = S_WSTAT;
                else if (beat_ok && RX_BEAT.last) begin
                    next_state = (take || pend) ? S_WDATA : S_WSTAT;
                end else if (take && (lane == 2'd3 || pos_inc == 8'(BUF_BYTES))) begin
                    next_state = S_WDATA;
                end
            end
            S_WDATA: begin
                if (MEM_ACK) begin
                    if (eof || buf_full) next_state = S_WSTAT;
                    else next_state = S_FILL;
                end
            end
            S_WSTAT: begin
                if (MEM_ACK) next_state = S_WOWN;
            end
            S_WOWN: begin
                if (MEM_ACK) next_state = eof ? S_IDLE : S_FETCH;
            end
            S_DISC: begin
                if (err_now || (beat_ok && RX_BEAT.last)) next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    assign RX_READY = (state == S_FILL && !buf_full && !err_pend) || (state == S_DISC);
    assign MEM_REQ = req_state && primed;
    assign BNA_EVENT = ack_fetch && owned;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= S_IDLE;
            ctrl <= rbm_pkg::RBM_CTRL_RST;
            cfg <= rbm_pkg::RBM_CFG_RST;
            qbase <= rbm_pkg::RBM_QPTR_RST;
            REG_RDATA <= 32'h0000_0000;
            bna <= 1'b0;
            primed <= 1'b0;
            MEM_OUT <= '0;
        end else begin
            state <= next_state;
            REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
            if (wr_ctrl) ctrl <= REG_WDATA;
            if (wr_cfg) cfg <= REG_WDATA;
            if (wr_qptr) qbase <= {REG_WDATA[31:2], 2'b00};
            // Set wins over a same-cycle write-one clear
            bna <= BNA_EVENT || (bna && !(wr_stat && REG_WDATA[rbm_pkg::RBM_STAT_BNA]));
            // Request waits one cycle so address and data are registered first
            primed <= req_state && !MEM_ACK && (next_state == state);
            MEM_OUT <= '{wr: (state != S_FETCH), addr: mem_addr_mux, wdata: mem_data_mux};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            idx <= 10'h000;
        end else if (wr_qptr) begin
            idx <= 10'h000;
        end else if (ack_own) begin
            idx <= wrap ? 10'h000 : idx + 10'h001;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            desc0 <= 32'h0000_0000;
            match <= '0;
            copy_ok <= 1'b0;
            err_pend <= 1'b0;
        end else begin
            if (ack_fetch) desc0 <= MEM_RDATA;
            if (state == S_WAITC && RX_COPY) match <= RX_MATCH;
            if (state == S_WAITC && RX_COPY) copy_ok <= 1'b1;
            else if (next_state == S_IDLE) copy_ok <= 1'b0;
            if (next_state == S_IDLE) err_pend <= 1'b0;
            else if (RX_ERR && state != S_IDLE) err_pend <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pos <= 8'h00;
            len <= 14'h0000;
            wbuf <= 32'h0000_0000;
            wword <= 5'h00;
            sof <= 1'b0;
            eof <= 1'b0;
            cont <= 1'b0;
            pend <= 1'b0;
        end else begin
            if (state == S_IDLE && RX_START && rx_en) begin
                pos <= {6'h00, cfg_ofs};
                len <= 14'h0000;
                sof <= 1'b1;
                eof <= 1'b0;
                cont <= 1'b0;
                pend <= 1'b0;
            end else if (state == S_FILL) begin
                wbuf <= next_wbuf;
                if (take) begin
                    pos <= pos_inc;
                    len <= len + 14'h0001;
                    wword <= pos[6:2];
                end
                pend <= (next_state == S_WDATA) ? 1'b0 : (pend || take);
                if (beat_ok && RX_BEAT.last) eof <= 1'b1;
            end else if (ack_own) begin
                pos <= 8'h00;
                sof <= 1'b0;
                cont <= !eof;
            end
        end
    end

    // =========================================================
    // Checks
    own_mark_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (MEM_REQ && state == S_WOWN) |-> (MEM_OUT.wr && MEM_OUT.wdata[0]))
        else $error("used bit not set in descriptor write-back");
    stat_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (MEM_REQ && state == S_WSTAT) |-> (MEM_OUT.addr == desc_addr + 32'h4))
        else $error("status word written to wrong address");
    wrap_return_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (ack_own && wrap && !wr_qptr) |=> (idx == 10'h000))
        else $error("ring did not return to start");
    desc_step_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (ack_own && !wrap && !wr_qptr) |=> (desc_addr == $past(desc_addr) + 32'h8))
        else $error("next descriptor not eight bytes on");
    bna_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (ack_fetch && owned) |=> (bna && state == S_DISC))
        else $error("owned descriptor not flagged");
    copy_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (MEM_REQ && state == S_WDATA) |-> copy_ok)
        else $error("data written before filter accepted frame");
    buf_bound_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (pos <= 8'(BUF_BYTES)) && (!(MEM_REQ && state == S_WDATA) ||
        ((MEM_OUT.addr - buf_base) < 32'(BUF_BYTES) && MEM_OUT.addr[1:0] == 2'b00)))
        else $error("write outside buffer");
    part_stat_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (MEM_REQ && state == S_WSTAT && !eof) |-> (MEM_OUT.wdata[31:15] == 17'h0 &&
        MEM_OUT.wdata[11:0] == 12'h000))
        else $error("continued buffer status not cleared");
    err_recover_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state == S_FILL && RX_ERR) |=> (state == S_IDLE && $stable(idx)))
        else $error("errored buffer not reclaimed");
    start_fetch_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state == S_IDLE && RX_START && rx_en) |=> ##1 (MEM_REQ && !MEM_OUT.wr))
        else $error("descriptor fetch not started");

    // =========================================================
    // Bus, status and buffer checks
    req_hold_a: assert property (
        (MEM_REQ && !MEM_ACK) |=> (MEM_REQ && $stable(MEM_OUT.addr) && $stable(MEM_OUT.wr)))
        else $error("memory request not held until ack");

    req_drop_a: assert property (MEM_ACK |=> !MEM_REQ)
        else $error("memory request held after ack");

    rd_zero_a: assert property (!REG_RD |=> (REG_RDATA == 32'h0000_0000))
        else $error("read data not zero outside a read");

    fetch_read_a: assert property (
        (MEM_REQ && state == S_FETCH) |-> (!MEM_OUT.wr && MEM_OUT.addr == desc_addr))
        else $error("descriptor fetch malformed");

    own_addr_a: assert property (
        (MEM_REQ && state == S_WOWN) |-> (MEM_OUT.addr == desc_addr))
        else $error("used mark written to wrong address");

    free_only_a: assert property (
        (MEM_REQ && state == S_WDATA) |-> !desc0[rbm_pkg::RBM_D0_OWN])
        else $error("data written into owned buffer");

    word_align_a: assert property (
        (MEM_REQ && MEM_OUT.wr) |-> (MEM_OUT.addr[1:0] == 2'b00))
        else $error("unaligned memory write");

    eof_flag_a: assert property (
        (MEM_REQ && state == S_WSTAT) |-> (MEM_OUT.wdata[15] == eof))
        else $error("end of frame flag wrong");

    sof_flag_a: assert property (
        (MEM_REQ && state == S_WSTAT) |-> (MEM_OUT.wdata[14] == sof))
        else $error("start of frame flag wrong");

    first_ofs_a: assert property (
        (state == S_IDLE && RX_START && rx_en) |=> (pos == {6'h00, $past(cfg_ofs)}))
        else $error("first buffer offset not applied");

    next_buf_a: assert property (
        (ack_own && !eof) |=> (state == S_FETCH && pos == 8'h00))
        else $error("frame did not move to a new buffer");

    fcs_skip_a: assert property (
        (beat_ok && drop_fcs) |=> $stable(len))
        else $error("discarded check byte counted");
endmodule : rbm_core

/* File: rbm_pkg.sv */
/*
 * Constants, field layouts and carrier types of the receive buffer manager.
 * Assumes a single core clock domain and a word-wide memory master port.
 */
// Behaviour
// - Each receive buffer holds exactly 128 bytes
// - Buffer address is word aligned, low bits ignored
// - First buffer data shifted by configured offset
// - Descriptor is address word plus status word
// - Continued buffer status: only start and offset
// - Mark used bit zero, then fetch next
// - Full status only in last descriptor
// - Word0: address, wrap, ownership; write if clear
// - Status bits 31..23 report address matches
// - Bits 22..20 report type, VLAN, priority tags
// - VLAN priority 19:17, CFI bit 16
// - Bit 15 marks end of frame
// - Bit 14 marks start of frame
// - Bits 13:12 offset, or length in jumbo
// - Length 11:0 includes FCS when stored
// - Fetch descriptor when frame data starts arriving
// - Write data only after filter accepts frame
// - Receive error reclaims the buffer being filled
// - Wrap or 1024th descriptor returns to start
// - Owned descriptor: skip, flag not available
// - FCS discard option shortens length by four
package rbm_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] RBM_OFS_CTRL = 8'h00;
    localparam logic [7:0] RBM_OFS_CFG = 8'h04;
    localparam logic [7:0] RBM_OFS_QPTR = 8'h08;
    localparam logic [7:0] RBM_OFS_STAT = 8'h0c;
    localparam int RBM_CTRL_RXEN = 0;
    localparam int RBM_CFG_JUMBO = 3;
    localparam int RBM_CFG_OFS_LO = 14;
    localparam int RBM_CFG_NOFCS = 17;
    localparam int RBM_STAT_BNA = 0;
    localparam int RBM_STAT_BUSY = 1;
    localparam logic [31:0] RBM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RBM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] RBM_QPTR_RST = 32'h0000_0000;

    // =========================================================
    // Descriptor layout
    localparam int RBM_D0_OWN = 0;
    localparam int RBM_D0_WRAP = 1;
    localparam logic [31:0] RBM_STAT_WORD_OFS = 32'h0000_0004;
    localparam int RBM_DESC_SHIFT = 3;
    localparam int RBM_DESC_MAX = 1024;
    localparam int RBM_BUF_BYTES = 128;
    localparam logic [15:0] RBM_TPID_VLAN = 16'h8100;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic bcast;
        logic mhash;
        logic uhash;
        logic ext;
        logic [3:0] spec;
        logic type_id;
        logic [15:0] type_field;
        logic [15:0] tci;
    } rbm_match_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic fcs;
    } rbm_beat_t;

    typedef struct packed {
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rbm_mem_t;

endpackage : rbm_pkg

/* File: rbm_stat.sv */
/*
 * Builds the descriptor status word from frame flags and counts.
 * Assumes match flags are held stable for the whole frame.
 */
`timescale 1ns/1ns
module rbm_stat (
    // Frame position
    input wire logic sof,
    input wire logic eof,
    // Frame properties
    input wire rbm_pkg::rbm_match_t match,
    input wire logic [1:0] offset,
    input wire logic jumbo,
    input wire logic [13:0] len,
    // Result
    output logic [31:0] word
);
    wire logic vlan = (match.type_field == rbm_pkg::RBM_TPID_VLAN);
    wire logic prio = vlan && (match.tci[11:0] == 12'h000);
    wire logic [1:0] mid = jumbo ? len[13:12] : offset;
    wire logic [31:0] full = {match.bcast, match.mhash, match.uhash, match.ext, 1'b0,
                              match.spec, match.type_id, vlan, prio,
                              match.tci[15:13], match.tci[12],
                              1'b1, sof, mid, len[11:0]};
    // Continued buffers carry only start flag and offset
    wire logic [31:0] part = {16'h0000, 1'b0, sof, (sof ? offset : 2'b00), 12'h000};

    assign word = eof ? full : part;
endmodule : rbm_stat

/* File: rbm_mem_model.sv */
/*
 * Word memory standing behind the block's master port, answering promptly
 * or after a few wait cycles. Assumes a held request and a one-cycle ack.
 */
`timescale 1ns/1ns
module rbm_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    input wire logic req,
    input wire rbm_pkg::rbm_mem_t mem,
    input wire logic slow,
    // Answer side
    output logic ack,
    output logic [31:0] rdata
);
    logic [31:0] words [0:255];
    logic [1:0] waited;

    // ==========
    // Answer logic
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            waited <= 2'h0;
            rdata <= 32'h5a5a_a5a5;
        end else begin
            ack <= 1'b0;
            // Read data is not held between answers, so it keeps changing
            rdata <= ~rdata;
            if (req && !ack) begin
                if (!slow || waited == 2'h3) begin
                    ack <= 1'b1;
                    waited <= 2'h0;
                    if (mem.wr) begin
                        words[mem.addr[9:2]] <= mem.wdata;
                    end else begin
                        rdata <= words[mem.addr[9:2]];
                    end
                end else begin
                    waited <= waited + 2'h1;
                end
            end
        end
    end
endmodule : rbm_mem_model

/* File: rx_buffer_descriptor_manager_test.sv */
/*
 * Self-checking bench of the receive buffer manager with a memory model.
 * Assumes the register map and descriptor layout of the design package.
 */
`timescale 1ns/1ns
module rx_buffer_descriptor_manager_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] ctl = 4'h0;
    rbm_pkg::rbm_match_t rx_match = '0;
    logic rx_valid = 1'b0;
    rbm_pkg::rbm_beat_t rx_beat = '0;
    logic rx_ready, mem_req, mem_ack, bna;
    rbm_pkg::rbm_mem_t mem_out;
    logic [31:0] mem_rdata;
    logic slow = 1'b0;
    int fails = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    // Short ring so that the count rollover is reached quickly
    rbm_core #(.DESC_MAX(4), .BUF_BYTES(128)) dut (
        .CORE_CLK(clk), .RSTN(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .RX_START(ctl[0]), .RX_COPY(ctl[1]), .RX_DROP(ctl[2]), .RX_MATCH(rx_match),
        .RX_VALID(rx_valid), .RX_BEAT(rx_beat), .RX_READY(rx_ready), .RX_ERR(ctl[3]),
        .MEM_REQ(mem_req), .MEM_OUT(mem_out), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
        .BNA_EVENT(bna));
    rbm_mem_model mem (.clk(clk), .rst_n(rst_n), .req(mem_req), .mem(mem_out),
        .slow(slow), .ack(mem_ack), .rdata(mem_rdata));

    // ==========
    // Reporting
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic hang(input string what);
        fails++;
        $display("unexpected at %0t: timeout waiting for %s", $time, what);
        end_sim();
    endtask : hang

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // ==========
    // Drivers
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask : reg_read

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        reg_read(a, d);
        chk(d, exp, what);
    endtask : reg_chk

    task automatic pulse(input logic [3:0] m);
        ctl <= m;
        @(posedge clk);
        ctl <= 4'h0;
    endtask : pulse

    // Ends at a falling edge once the chosen flag is high
    task automatic wait_for(input int which, input string what);
        logic hit;
        for (int n = 0; n < 3000; n++) begin
            @(negedge clk);
            hit = (which == 0) ? mem_req : (which == 1) ? mem_ack : (which == 2) ? bna : rx_ready;
            if (hit === 1'b1) return;
        end
        hang(what);
    endtask : wait_for

    task automatic put_byte(input logic [7:0] d, input logic l, input logic f);
        rx_valid <= 1'b1;
        rx_beat <= {d, l, f};
        wait_for(3, "stream ready");
        @(posedge clk);
    endtask : put_byte

    task automatic wait_idle;
        logic [31:0] s;
        for (int n = 0; n < 400; n++) begin
            reg_read(rbm_pkg::RBM_OFS_STAT, s);
            if (s[rbm_pkg::RBM_STAT_BUSY] === 1'b0) return;
        end
        hang("idle");
    endtask : wait_idle

    task automatic rx_frame(input logic [31:0] desc, input int n, input int fcs_from,
                            input logic [7:0] seed, input logic copy, input int err_at);
        pulse(4'h1);
        wait_for(0, "descriptor fetch");
        chk({31'h0, mem_out.wr}, 32'h0, "fetch is a read");
        chk(mem_out.addr, desc, "fetch address");
        wait_for(1, "fetch ack");
        @(posedge clk);
        pulse(copy ? 4'h2 : 4'h4);
        for (int i = 0; copy && i < n; i++) begin
            if (i == err_at) begin
                rx_valid <= 1'b0;
                pulse(4'h8);
                break;
            end
            put_byte(seed + 8'(i), i == n - 1, i >= fcs_from);
        end
        rx_valid <= 1'b0;
        wait_idle();
    endtask : rx_frame

    task automatic init_ring(input int wrap_at);
        for (int i = 0; i < 4; i++) begin
            mem.words[2 * i] = 32'h100 + 32'(i) * 32'h80 + ((i == wrap_at) ? 32'h2 : 32'h0);
            mem.words[2 * i + 1] = 32'h0;
        end
    endtask : init_ring

    // ==========
    // Scenarios
    task automatic t_regs;
        reg_chk(rbm_pkg::RBM_OFS_CTRL, rbm_pkg::RBM_CTRL_RST, "ctrl reset");
        reg_chk(rbm_pkg::RBM_OFS_CFG, rbm_pkg::RBM_CFG_RST, "cfg reset");
        reg_chk(rbm_pkg::RBM_OFS_STAT, 32'h0, "stat reset");
        reg_write(8'h10, 32'hffff_ffff);
        reg_chk(8'h10, 32'h0, "unmapped read");
        reg_write(rbm_pkg::RBM_OFS_QPTR, 32'h0000_0003);
        reg_chk(rbm_pkg::RBM_OFS_QPTR, 32'h0, "pointer aligned");
        reg_write(rbm_pkg::RBM_OFS_CTRL, 32'h1);
        reg_chk(rbm_pkg::RBM_OFS_CTRL, 32'h1, "enable");
        $display("done: registers");
    endtask : t_regs

    task automatic t_single;
        rx_match <= {4'b1000, 4'ha, 1'b1, rbm_pkg::RBM_TPID_VLAN, 16'ha005};
        rx_frame(32'h0, 5, 4, 8'h10, 1'b1, 99);
        chk(mem.words[64], 32'h1312_1110, "packed word");
        chk(mem.words[65] & 32'hff, 32'h14, "tail byte");
        chk(mem.words[1], 32'h856a_c005, "whole frame status");
        chk(mem.words[0], 32'h101, "used mark");
        reg_chk(rbm_pkg::RBM_OFS_QPTR, 32'h8, "next entry");
        $display("done: single buffer frame");
    endtask : t_single

    task automatic t_long;
        slow <= 1'b1;
        reg_write(rbm_pkg::RBM_OFS_CFG, 32'h0000_8000);
        rx_match <= {4'b0111, 4'h5, 1'b0, rbm_pkg::RBM_TPID_VLAN, 16'h3000};
        rx_frame(32'h8, 130, 999, 8'h40, 1'b1, 999);
        chk(mem.words[96] & 32'hffff_0000, 32'h4140_0000, "shifted start");
        chk(mem.words[127] & 32'hff00_0000, 32'hbd00_0000, "first buffer end");
        chk(mem.words[128], 32'hc1c0_bfbe, "second buffer");
        chk(mem.words[3], 32'h0000_6000, "partial status");
        chk(mem.words[5], 32'h72b3_a082, "final status");
        chk(mem.words[2], 32'h181, "first used");
        chk(mem.words[4], 32'h201, "second used");
        reg_chk(rbm_pkg::RBM_OFS_QPTR, 32'h18, "after two");
        slow <= 1'b0;
        $display("done: two buffer frame");
    endtask : t_long

    task automatic t_jumbo;
        reg_write(rbm_pkg::RBM_OFS_CFG, 32'h0002_4008);
        rx_match <= '0;
        rx_frame(32'h18, 6, 2, 8'h70, 1'b1, 99);
        chk(mem.words[160] & 32'h00ff_ff00, 32'h0071_7000, "offset one");
        chk(mem.words[7], 32'h0000_c002, "jumbo, no check bytes");
        chk(mem.words[6], 32'h281, "last used");
        reg_chk(rbm_pkg::RBM_OFS_QPTR, 32'h0, "count rollover");
        $display("done: jumbo frame");
    endtask : t_jumbo

    task automatic t_owned;
        reg_write(rbm_pkg::RBM_OFS_CFG, 32'h0);
        pulse(4'h1);
        wait_for(2, "not available event");
        @(posedge clk);
        pulse(4'h8);
        wait_idle();
        chk(mem.words[0], 32'h101, "owned untouched");
        reg_chk(rbm_pkg::RBM_OFS_STAT, 32'h1, "sticky flag");
        reg_write(rbm_pkg::RBM_OFS_STAT, 32'h1);
        reg_chk(rbm_pkg::RBM_OFS_STAT, 32'h0, "flag cleared");
        $display("done: owned descriptor");
    endtask : t_owned

    task automatic t_drop_err;
        init_ring(0);
        reg_write(rbm_pkg::RBM_OFS_QPTR, 32'h0);
        rx_frame(32'h0, 3, 99, 8'h20, 1'b0, 99);
        chk(mem.words[1], 32'h0, "dropped frame");
        chk(mem.words[0], 32'h102, "dropped keeps buffer");
        rx_frame(32'h0, 10, 99, 8'h30, 1'b1, 6);
        chk(mem.words[0], 32'h102, "reclaimed");
        chk(mem.words[1], 32'h0, "no status");
        rx_frame(32'h0, 5, 99, 8'h10, 1'b1, 99);
        chk(mem.words[1], 32'h0000_c005, "reuse");
        chk(mem.words[0], 32'h103, "reused and marked");
        reg_chk(rbm_pkg::RBM_OFS_QPTR, 32'h0, "wrap return");
        $display("done: drop and error");
    endtask : t_drop_err

    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        init_ring(9);
        t_regs();
        t_single();
        t_long();
        t_jumbo();
        t_owned();
        t_drop_err();
        end_sim();
    end

    initial begin
        #10_000_000;
        hang("end of run");
    end
endmodule : rx_buffer_descriptor_manager_test
